// >>> msc_pkg.sv
package msc_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam int MSC_ADDR_W = 4;
  localparam logic [3:0] MSC_OFS_CFG_A = 4'h0;
  localparam logic [3:0] MSC_OFS_CFG_B = 4'h4;
  localparam logic [3:0] MSC_OFS_STATUS = 4'h8;
  localparam logic [15:0] MSC_CFG_A_RST = 16'h0000;
  localparam logic [15:0] MSC_CFG_B_RST = 16'h0000;
  localparam logic [1:0] MSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] MSC_RESP_SLVERR = 2'h2;

  // mf_sync_config_a fields
  localparam int MSC_A_DETECT_EN = 0;
  localparam int MSC_A_SRC_LO = 1;
  localparam int MSC_A_GUARD = 3;
  localparam int MSC_A_MOD_EN = 4;
  localparam int MSC_A_MOD_RATE = 5;
  localparam int MSC_A_LINE_EN = 6;
  localparam int MSC_A_LINE_RATE = 7;
  localparam int MSC_A_OFFSET_LO = 8;

  // mf_sync_config_b fields
  localparam int MSC_B_DELAY_LO = 0;
  localparam int MSC_B_LONG = 4;
  localparam int MSC_B_NT_MODE = 5;
  localparam int MSC_B_DRIVE_EN = 6;

  // ***************************************************************
  // Counter figures
  // ***************************************************************
  localparam logic [5:0] MSC_CNT_LAST = 6'h27;
  localparam logic [5:0] MSC_GUARD_LONG = 6'h27;
  localparam logic [5:0] MSC_GUARD_SHORT = 6'h07;
  localparam logic [6:0] MSC_CNT_SPAN = 7'h28;
  localparam logic [9:0] MSC_FLEN_MIN = 10'h004;

  typedef enum logic [1:0] {
    MSC_SRC_FRAME,
    MSC_SRC_SYNC_PIN,
    MSC_SRC_DATA_ONE,
    MSC_SRC_MF_IN
  } msc_src_t;

endpackage : msc_pkg

// >>> msc_pin_if.sv
`timescale 1ns/10ps
interface msc_pin_if;
  logic c4_fall;
  logic frame_s;
  logic sync_s;
  logic data_s;

  modport src (
    output c4_fall,
    output frame_s,
    output sync_s,
    output data_s
  );

  modport dst (
    input c4_fall,
    input frame_s,
    input sync_s,
    input data_s
  );
endinterface : msc_pin_if

// >>> msc_pin_sync.sv
`timescale 1ns/10ps
module msc_pin_sync (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Raw pins
  input wire logic pcm_double_bit_clock,
  input wire logic frame_pin,
  input wire logic sync_pin,
  input wire logic data_pin,
  // Synchronised view
  msc_pin_if.src pins
);
  import msc_pkg::*;

  typedef struct packed {
    logic [3:0] ff1;
    logic [3:0] ff2;
    logic c4_last;
    logic fall;
  } msc_sync_t;

  msc_sync_t s;
  msc_sync_t next_s;

  always_comb begin
    next_s = s;
    // First stage feeds the second stage only
    next_s.ff1 = {pcm_double_bit_clock, frame_pin, sync_pin, data_pin};
    next_s.ff2 = s.ff1;
    next_s.c4_last = s.ff2[3];
    next_s.fall = s.c4_last & ~s.ff2[3];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pins.c4_fall = s.fall;
  assign pins.frame_s = s.ff2[2];
  assign pins.sync_s = s.ff2[1];
  assign pins.data_s = s.ff2[0];

endmodule : msc_pin_sync

// >>> msc_frame_sync.sv
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
// Functional notes
// - Frame counter steps on every frame pulse and wraps 39 to 0.
// - A qualified sync event resets the counter, aligning it to the source.
// - Detection off: counter runs free, pulses still generated.
// - Detection and resets only while the detect enable bit is set.
// - Sync source is frame pulse, sync pin, data line one or mf_sync_in.
// - Source sampled delay+1 bit-clock periods after frame start, delay 0..15.
// - Event only when sample differs from previous frame's sample.
// - Event closes window; reopens at count 39, or 7 with guard bit set.
// - Reset needs enable, open window, elapsed delay and changed input together.
// - On data line one an even delay lands the sample in a bit cell.
// - Frame pulse high one bit-clock period, or two with long bit set.
// - Modification adds one period every 40th frame, or every 8th frame.
// - Long pulse moves leading edge earlier; mark delays trailing edge.
// - Frame alignment taken at first falling bit-clock edge in high time; while driving the pin, frame start runs on the learned length.
// - Line sync pulse delivered only while line sync enable is set.
// - Line sync pulse every 40th or 8th frame per rate bit.
// - Line sync shifted by signed offset of -4..+3 frames.
// - Line sync applied only when line is in network-side mode.
module msc_frame_sync (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [msc_pkg::MSC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [msc_pkg::MSC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // PCM bus
  input wire logic pcm_double_bit_clock,
  input wire logic pcm_frame_pulse_i,
  output logic pcm_frame_pulse_o,
  output logic pcm_frame_pulse_oe,
  input wire logic pcm_data_line_one,
  // Sync inputs
  input wire logic sync_in,
  input wire logic mf_sync_in,
  // Line interface
  output logic mf_sync_to_line
);
  import msc_pkg::*;

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [15:0] cfg_a;
    logic [15:0] cfg_b;
    logic awready;
    logic aw_got;
    logic [MSC_ADDR_W-1:0] awaddr;
    logic wready;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic fp_prev;
    logic [9:0] pos;
    logic [9:0] flen;
    logic [5:0] cnt;
    logic win;
    logic samp_prev;
    logic aligned;
    logic fp_out;
    logic line_pulse;
  } msc_state_t;

  msc_state_t s;
  msc_state_t next_s;
  msc_pin_if pins ();

  msc_pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pcm_double_bit_clock(pcm_double_bit_clock),
    .frame_pin(pcm_frame_pulse_i),
    .sync_pin(sync_in),
    .data_pin(pcm_data_line_one),
    .pins(pins)
  );

  // ***************************************************************
  // Configuration views
  // ***************************************************************
  logic detect_en;
  msc_src_t src_sel;
  logic guard_sel;
  logic mod_en;
  logic mod_rate;
  logic line_en;
  logic line_rate;
  logic [2:0] line_offset;
  logic [3:0] sample_delay;
  logic pulse_long;
  logic nt_mode;

  assign detect_en = s.cfg_a[MSC_A_DETECT_EN];
  assign src_sel = msc_src_t'(s.cfg_a[MSC_A_SRC_LO +: 2]);
  assign guard_sel = s.cfg_a[MSC_A_GUARD];
  assign mod_en = s.cfg_a[MSC_A_MOD_EN];
  assign mod_rate = s.cfg_a[MSC_A_MOD_RATE];
  assign line_en = s.cfg_a[MSC_A_LINE_EN];
  assign line_rate = s.cfg_a[MSC_A_LINE_RATE];
  assign line_offset = s.cfg_a[MSC_A_OFFSET_LO +: 3];
  assign sample_delay = s.cfg_b[MSC_B_DELAY_LO +: 4];
  assign pulse_long = s.cfg_b[MSC_B_LONG];
  assign nt_mode = s.cfg_b[MSC_B_NT_MODE];

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = d[7:0];
    end
    if (strb[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction : merge16

  // ***************************************************************
  // Frame timing helpers
  // ***************************************************************
  logic fstart;
  logic take;
  logic src_val;
  logic sync_evt;
  logic [9:0] pn;
  logic [5:0] cnt_after;
  logic [5:0] guard_target;
  logic [6:0] adj_raw;
  logic [6:0] adj;
  logic mark_mod;
  logic mark_line;

  always_comb begin
    // Frame aligned at the first falling edge seen high; while we drive the pin our own
    // early edge would pull us forward, so run on the learned length instead
    fstart = pins.c4_fall & ((s.cfg_b[MSC_B_DRIVE_EN] & (s.flen >= MSC_FLEN_MIN)) ?
                             (s.pos + 10'h001 == s.flen) : (pins.frame_s & ~s.fp_prev));
    pn = fstart ? 10'h000 : ((s.pos == 10'h3FF) ? s.pos : s.pos + 10'h001);
    // Even delays hit data bit cells on data line one
    take = pins.c4_fall & ~fstart & (pn == {5'h00, 1'b0, sample_delay} + 10'h001);
    unique case (src_sel)
      MSC_SRC_FRAME: src_val = pins.frame_s;
      MSC_SRC_SYNC_PIN: src_val = pins.sync_s;
      MSC_SRC_DATA_ONE: src_val = pins.data_s;
      MSC_SRC_MF_IN: src_val = mf_sync_in;
    endcase
    sync_evt = detect_en & s.win & take & (src_val != s.samp_prev);
    cnt_after = (s.cnt == MSC_CNT_LAST) ? 6'h00 : s.cnt + 6'h01;
    guard_target = guard_sel ? MSC_GUARD_SHORT : MSC_GUARD_LONG;
    mark_mod = mod_rate ? (cnt_after[2:0] == 3'h0) : (cnt_after == 6'h00);
    // Offset folded back into 0..39
    adj_raw = {1'b0, cnt_after} + MSC_CNT_SPAN - {{4{line_offset[2]}}, line_offset};
    if (adj_raw >= (MSC_CNT_SPAN << 1)) begin
      adj = adj_raw - (MSC_CNT_SPAN << 1);
    end else if (adj_raw >= MSC_CNT_SPAN) begin
      adj = adj_raw - MSC_CNT_SPAN;
    end else begin
      adj = adj_raw;
    end
    mark_line = line_rate ? (adj[2:0] == 3'h0) : (adj == 7'h00);
  end

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    next_s = s;

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = MSC_RESP_OKAY;
      unique case (s.awaddr)
        MSC_OFS_CFG_A: next_s.cfg_a = merge16(s.cfg_a, s.wdata, s.wstrb);
        MSC_OFS_CFG_B: next_s.cfg_b = merge16(s.cfg_b, s.wdata, s.wstrb);
        MSC_OFS_STATUS: next_s.bresp = MSC_RESP_OKAY;
        default: next_s.bresp = MSC_RESP_SLVERR;
      endcase
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    next_s.awready = ~next_s.aw_got & ~next_s.bvalid;
    next_s.wready = ~next_s.w_got & ~next_s.bvalid;

    // Read channel
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = MSC_RESP_OKAY;
      unique case (s_axi_araddr)
        MSC_OFS_CFG_A: next_s.rdata = {16'h0000, s.cfg_a};
        MSC_OFS_CFG_B: next_s.rdata = {16'h0000, s.cfg_b};
        MSC_OFS_STATUS: next_s.rdata = {14'h0000, s.flen, s.aligned, s.win, s.cnt};
        default: begin
          next_s.rdata = 32'h00000000;
          next_s.rresp = MSC_RESP_SLVERR;
        end
      endcase
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    next_s.arready = ~next_s.rvalid;

    // Frame position within the PCM frame, counted in bit-clock periods
    if (pins.c4_fall) begin
      next_s.fp_prev = pins.frame_s;
      next_s.pos = pn;
      if (fstart) begin
        next_s.flen = s.pos + 10'h001;
      end
    end

    // Counter and detection window
    next_s.line_pulse = 1'b0;
    if (fstart) begin
      next_s.cnt = cnt_after;
      next_s.line_pulse = line_en & nt_mode & mark_line;
    end
    if (take) begin
      next_s.samp_prev = src_val;
    end
    if (sync_evt) begin
      next_s.cnt = 6'h00;
      next_s.win = 1'b0;
      next_s.aligned = 1'b1;
    end else if (s.cnt == guard_target) begin
      next_s.win = 1'b1;
    end
    if (!detect_en) begin
      next_s.aligned = 1'b0;
    end

    // Outgoing frame pulse, built per bit-clock period
    if (pins.c4_fall) begin
      if (s.flen < MSC_FLEN_MIN) begin
        next_s.fp_out = 1'b0;
      end else if (fstart) begin
        next_s.fp_out = mod_en & mark_mod;
      end else begin
        next_s.fp_out = (pn == s.flen - 10'h001) |
                        (pulse_long & (pn == s.flen - 10'h002));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.cfg_a <= MSC_CFG_A_RST;
      s.cfg_b <= MSC_CFG_B_RST;
      s.win <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign pcm_frame_pulse_o = s.fp_out;
  assign pcm_frame_pulse_oe = s.cfg_b[MSC_B_DRIVE_EN];
  assign mf_sync_to_line = s.line_pulse;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  counter_wrap_a: assert property (fstart && !sync_evt && s.cnt == 6'h27 |=> s.cnt == 6'h00)
    else $error("frame counter did not wrap after 39");
  counter_step_a: assert property (fstart && s.cnt < 6'h27 |=> s.cnt == $past(s.cnt) + 6'h01)
    else $error("frame counter did not step on frame start");
  counter_bound_a: assert property (s.cnt <= 6'h27)
    else $error("frame counter left 0..39");
  sync_reset_a: assert property (sync_evt |=> s.cnt == 6'h00 && !s.win && s.aligned)
    else $error("sync event did not reset counter and close window");
  free_run_a: assert property (!detect_en && !fstart |=> s.cnt == $past(s.cnt) && !s.aligned)
    else $error("counter moved off frame start while detection disabled");
  sample_delay_a: assert property (sync_evt |-> s.pos + 10'h001 == {6'h00, sample_delay} + 10'h001)
    else $error("sync sampled at wrong delay");
  change_only_a: assert property (take && src_val == s.samp_prev |=> s.cnt == $past(s.cnt))
    else $error("counter reset without a change");
  window_closed_a: assert property (!s.win && !fstart |=> s.cnt == $past(s.cnt))
    else $error("counter reset with window closed");
  window_reopen_a: assert property (!s.win && s.cnt == guard_target && !sync_evt |=> s.win)
    else $error("window did not reopen at guard count");
  line_gate_a: assert property (mf_sync_to_line |-> $past(line_en) && $past(nt_mode))
    else $error("line sync while disabled or not network side");
  line_single_a: assert property (mf_sync_to_line |=> !mf_sync_to_line)
    else $error("line sync longer than one cycle");
  line_rate_a: assert property (mf_sync_to_line && !$past(line_rate) |-> $past(adj) == 7'h00)
    else $error("line sync at wrong offset frame");
  pulse_short_a: assert property (pins.c4_fall && !fstart && !pulse_long && s.flen >= 10'h004 &&
                                  pn == s.flen - 10'h002 |=> !pcm_frame_pulse_o)
    else $error("short frame pulse started early");
  pulse_long_a: assert property (pins.c4_fall && !fstart && pulse_long && s.flen >= 10'h004 &&
                                 pn == s.flen - 10'h002 |=> pcm_frame_pulse_o)
    else $error("long frame pulse missing early edge");

  sync_seen_c: cover property (sync_evt);
  line_sync_c: cover property (mf_sync_to_line);
  mark_pulse_c: cover property (fstart && mod_en && mark_mod);
  wrap_c: cover property (fstart && s.cnt == 6'h27);

endmodule : msc_frame_sync

// >>> msc_pcm_master.sv
`timescale 1ns/10ps
module msc_pcm_master #(
  parameter int FLEN = 16
) (
  // Control
  input wire logic run,
  // PCM bus
  output logic bclk,
  output logic fp,
  // Frames sent so far
  output int frames
);
  // ********
  // Bit clock and frame pulse
  // ********
  int per;
  initial begin
    bclk = 1'b0;
    fp = 1'b0;
    frames = 0;
    per = 0;
    wait (run);
    forever begin
      #100 bclk = 1'b1;
      // Pulse covers a single falling edge, the one a receiver aligns on
      fp = (per == FLEN - 1);
      #200 bclk = 1'b0;
      if (fp)
        frames = frames + 1;
      per = (per + 1) % FLEN;
      #100;
    end
  end
endmodule : msc_pcm_master

// >>> test_multiframe_sync_controller.sv
`timescale 1ns/10ps
`define CMP(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: %h vs %h", $time, (a), (e)); end end
module test_multiframe_sync_controller;
  import msc_pkg::*;
  localparam int FLEN = 16;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic sync_in = 1'b0;
  logic mf_sync_in = 1'b0;
  logic pcm_data_line_one = 1'b0;
  logic run = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, r;
  logic pcm_double_bit_clock, pcm_frame_pulse_i, pcm_frame_pulse_o, pcm_frame_pulse_oe;
  logic mf_sync_to_line, fp_m;
  int frames, mismatches, checked, cycles, pulses, hi, fps, line_off, fp_long, fp_mod, fp_chk;
  int line_mod = 8;
  int fp_rate = 8;
  logic [33:0] expq[$];
  logic [33:0] e;

  // Shared frame pulse wire
  assign pcm_frame_pulse_i = pcm_frame_pulse_oe ? pcm_frame_pulse_o : fp_m;

  msc_frame_sync uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pcm_double_bit_clock, .pcm_frame_pulse_i, .pcm_frame_pulse_o,
    .pcm_frame_pulse_oe, .pcm_data_line_one, .sync_in, .mf_sync_in, .mf_sync_to_line
  );
  msc_pcm_master #(.FLEN(FLEN)) u_pcm (
    .run, .bclk(pcm_double_bit_clock), .fp(fp_m), .frames
  );

  initial begin
    forever #25 aclk = ~aclk;
  end

  // ********
  // Bus and frame helpers
  // ********
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] x);
    expq.push_back({x, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [33:0] x);
    expq.push_back(x);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  function automatic logic [33:0] st(input int c, input logic w, input logic al, input int n);
    return {2'h0, 14'h0, n[9:0], al, w, c[5:0]};
  endfunction : st

  // Lands 20 clock cycles after a frame start, clear of that edge
  task automatic fwait(input int k);
    int t;
    t = frames + k;
    while (frames < t)
      @(posedge aclk);
    repeat (20)
      @(posedge aclk);
  endtask : fwait

  // Flip a source early in a frame, before its sample point
  task automatic kick(input int s);
    int t;
    t = frames;
    while (frames == t)
      @(posedge aclk);
    case (s)
      1: sync_in <= ~sync_in;
      2: pcm_data_line_one <= ~pcm_data_line_one;
      default: mf_sync_in <= ~mf_sync_in;
    endcase
  endtask : kick

  task conclude;
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // ********
  // Output watcher
  // ********
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      conclude();
    end
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
      e = expq.pop_front();
      if (s_axi_bvalid)
        `CMP({s_axi_bresp, 32'h0}, e)
      else
        `CMP({s_axi_rresp, s_axi_rdata}, e)
    end
    if (mf_sync_to_line) begin
      `CMP(((frames - line_off) % line_mod + 40) % line_mod, 0)
      pulses++;
    end
    if (pcm_frame_pulse_o && pcm_frame_pulse_oe)
      hi++;
    else if (hi > 0) begin
      if (fp_chk) begin
        `CMP((hi + 4) / 8, 1 + fp_long + int'(fp_mod && frames % fp_rate == 0))
        fps++;
      end
      hi = 0;
    end
  end

  // ********
  // Main sequence
  // ********
  initial begin
    repeat (12)
      @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    void'($urandom(32'hA9F5));
    rd(MSC_OFS_CFG_A, 34'h0);
    rd(MSC_OFS_STATUS, st(0, 1'b1, 1'b0, 0));
    rd(4'hC, {MSC_RESP_SLVERR, 32'h0});
    wr(4'hC, 32'hFFFF, MSC_RESP_SLVERR);
    wr(MSC_OFS_STATUS, 32'hFFFF, MSC_RESP_OKAY);
    rd(MSC_OFS_STATUS, st(0, 1'b1, 1'b0, 0));
    for (int i = 0; i < 2; i++) begin
      r = $urandom() & (i ? 32'hFFFF_007F : 32'hFFFF_07FF);
      wr(i ? MSC_OFS_CFG_B : MSC_OFS_CFG_A, r, MSC_RESP_OKAY);
      rd(i ? MSC_OFS_CFG_B : MSC_OFS_CFG_A, {2'h0, 16'h0, r[15:0]});
    end
    wr(MSC_OFS_CFG_B, 32'h22, MSC_RESP_OKAY);
    run <= 1'b1;
    for (int o = -4; o < 4; o++) begin
      line_off = o;
      wr(MSC_OFS_CFG_A, {21'h0, 3'(o), 8'hC0}, MSC_RESP_OKAY);
      pulses = 0;
      fwait(8);
      `CMP(pulses, 1)
    end
    line_mod = 40;
    line_off = 3;
    wr(MSC_OFS_CFG_A, 32'h340, MSC_RESP_OKAY);
    pulses = 0;
    fwait(40);
    `CMP(pulses, 1)
    wr(MSC_OFS_CFG_A, 32'h82, MSC_RESP_OKAY);
    sync_in <= 1'b1;
    pulses = 0;
    fwait(9);
    `CMP(pulses, 0)
    rd(MSC_OFS_STATUS, st(frames % 40, 1'b1, 1'b0, FLEN));
    wr(MSC_OFS_CFG_B, 32'h02, MSC_RESP_OKAY);
    wr(MSC_OFS_CFG_A, 32'hC0, MSC_RESP_OKAY);
    pulses = 0;
    fwait(9);
    `CMP(pulses, 0)
    for (int i = 0; i < 4; i++) begin
      fp_long = i % 2;
      fp_mod = i / 2;
      fp_rate = i == 3 ? 40 : 8;
      fp_chk = 0;
      wr(MSC_OFS_CFG_A, {26'h0, i == 2, i > 1, 4'h0}, MSC_RESP_OKAY);
      wr(MSC_OFS_CFG_B, {25'h0, 2'h2, 1'(fp_long), 4'h2}, MSC_RESP_OKAY);
      fwait(1);
      fp_chk = 1;
      fwait(fp_rate);
    end
    fp_chk = 0;
    `CMP(fps > 20, 1'b1)
    wr(MSC_OFS_CFG_B, 32'h22, MSC_RESP_OKAY);
    for (int s = 3; s > 0; s--) begin
      wr(MSC_OFS_CFG_A, 32'(9 + 2 * s), MSC_RESP_OKAY);
      fwait(9);
      kick(s);
      fwait(2);
      rd(MSC_OFS_STATUS, st(2, 1'b0, 1'b1, FLEN));
      kick(s);
      fwait(3);
      rd(MSC_OFS_STATUS, st(6, 1'b0, 1'b1, FLEN));
      fwait(2);
      rd(MSC_OFS_STATUS, st(8, 1'b1, 1'b1, FLEN));
    end
    wr(MSC_OFS_CFG_A, 32'h03, MSC_RESP_OKAY);
    kick(1);
    fwait(38);
    rd(MSC_OFS_STATUS, st(38, 1'b0, 1'b1, FLEN));
    fwait(1);
    rd(MSC_OFS_STATUS, st(39, 1'b1, 1'b1, FLEN));
    conclude();
  end
endmodule : test_multiframe_sync_controller
